// ---- rtl/dsl_pkg.sv ----
// Purpose: Shared constants for the dual DAC serial load logic.
// Assumes: One shared shift register feeding two DAC holding registers.
// Notes: Widths are module parameters; these are the documented defaults.
package dsl_pkg;

    // Converter resolution of the wide variant; the narrow variant uses 10
    localparam int DAC_WIDTH = 12;
    localparam int NUM_CHAN = 2;
    localparam int CHAN_A = 0;
    localparam int CHAN_B = 1;

    // Values taken at reset; PIN_IDLE_HIGH is the level shifted in as clear releases
    localparam logic SHIFT_RST_BIT = 1'b0;
    localparam logic CODE_RST_BIT = 1'b0;
    localparam logic MID_MSB_BIT = 1'b1;
    localparam logic PIN_IDLE_HIGH = 1'b1;

    // Clock cycles the shift word must be quiet before it is copied across
    localparam logic [1:0] SETTLE_CYCLES = 2'h2;

    typedef enum logic [1:0] {
        DSL_LINK_IDLE,
        DSL_LINK_BUSY,
        DSL_LINK_SETTLE
    } dsl_link_state_t;

endpackage

// ---- rtl/dsl_sync.sv ----
// Purpose: Two flip-flop synchroniser for a group of independent levels.
// Assumes: Each bit is a slow level; bits are not a coherent word.
// Notes: Only the second stage may be read by other logic.
`timescale 1ns/1ps
module dsl_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] q_r;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= RST_VAL;
            q_r <= RST_VAL;
        end else begin
            meta_r <= d;
            q_r <= meta_r;
        end
    end

    assign q = q_r;

endmodule

// ---- rtl/dsl_shift.sv ----
// Purpose: Serial input shift register on the link clock.
// Assumes: The host changes data and chip select away from the rising link edge.
// Notes: Word width equals the converter width, so surplus early bits fall off.
`timescale 1ns/1ps
module dsl_shift #(
    parameter int WIDTH = dsl_pkg::DAC_WIDTH
) (
    input wire logic sclk,
    input wire logic rst_b,
    input wire logic chip_select_n,
    input wire logic serial_data_in,
    output logic [WIDTH-1:0] shift_word
);

    logic [WIDTH-1:0] word_r;
    logic [WIDTH-1:0] word_nxt;

    always_comb begin
        word_nxt = word_r;
        if (!chip_select_n) begin
            word_nxt = {word_r[WIDTH-2:0], serial_data_in};
        end
    end

    always_ff @(posedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            word_r <= {WIDTH{dsl_pkg::SHIFT_RST_BIT}};
        end else begin
            word_r <= word_nxt;
        end
    end

    assign shift_word = word_r;

    property p_shift_in;
        @(posedge sclk) disable iff (!rst_b)
        !chip_select_n |=> shift_word == {$past(shift_word[WIDTH-2:0]), $past(serial_data_in)};
    endproperty
    chk_shift_msb_first: assert property (p_shift_in)
        else $error("shift word did not take the new bit at the low end");

    chk_shift_cs_hold: assert property (@(posedge sclk) disable iff (!rst_b)
        chip_select_n |=> $stable(shift_word))
        else $error("shift word changed with chip select high");

    cov_shift_frame: cover property (@(posedge sclk) disable iff (!rst_b)
        (!chip_select_n) [*8] ##1 chip_select_n);

endmodule

// ---- rtl/dsl_dual_dac_load.sv ----
// Behaviour
// - One shared serial shift register feeds two DAC holding registers, A and B.
// - Each rising serial clock edge with chip select low samples the data line into the shift register.
// - Words arrive most significant bit first, shifting toward the top end.
// - Shifting happens only while chip select is low; otherwise contents hold.
// - Surplus bits push out the earliest ones; only the latest bits stay.
// - On the ten-bit variant only the final ten bits form the code.
// - Load strobe A low copies the word to A; strobe B to B.
// - Strobes are level sensitive; a held strobe keeps its register following.
// - Clear low forces zeros, or midscale when midscale select is high.
// - Each register drives its converter as an unsigned straight binary code.
// - Sleep low puts the converters to sleep; release restores normal running.
// - Chip select has no effect on the load strobes.
// - Midscale means top bit one and every lower bit zero.
// - Clear acts at once, without waiting for any clock edge.
// - Sleep keeps all contents and still accepts shifts and loads.
//
// Purpose: Digital front end of a dual voltage output DAC with serial loading.
// Assumes: The link clock only runs inside frames; clk is free running.
// Notes: The shift word crosses to clk only while the link is quiet.
`timescale 1ns/1ps
module dsl_dual_dac_load #(
    parameter int DAC_W = dsl_pkg::DAC_WIDTH
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sclk,
    input wire logic chip_select_n,
    input wire logic serial_data_in,
    input wire logic load_chan_a_n,
    input wire logic load_chan_b_n,
    input wire logic register_clear_n,
    input wire logic midscale_sel,
    input wire logic sleep_n,
    output logic [DAC_W-1:0] dac_code_a,
    output logic [DAC_W-1:0] dac_code_b,
    output logic converter_sleep,
    output logic frame_active
);

    localparam int NCH = dsl_pkg::NUM_CHAN;

    logic [DAC_W-1:0] shift_word;
    logic [3:0] pins_s;
    logic cs_n_s;
    logic sleep_n_s;
    logic [NCH-1:0] load_n_s;
    logic msel_s;
    logic clr_rst_b;
    logic clr_meta_r;
    logic clr_sync_r;
    logic clear_hold_b;

    // Link side: the shift register is the only logic on the link clock
    dsl_shift #(
        .WIDTH(DAC_W)
    ) u_shift (
        .sclk(sclk),
        .rst_b(rst_b),
        .chip_select_n(chip_select_n),
        .serial_data_in(serial_data_in),
        .shift_word(shift_word)
    );

    // Pin levels into clk; strobes idle high so they read as released in reset
    dsl_sync #(
        .WIDTH(4),
        .RST_VAL(4'hf)
    ) u_pin_sync (
        .clk(clk),
        .rst_b(rst_b),
        .d({sleep_n, chip_select_n, load_chan_b_n, load_chan_a_n}),
        .q(pins_s)
    );

    dsl_sync #(
        .WIDTH(1),
        .RST_VAL(1'h0)
    ) u_msel_sync (
        .clk(clk),
        .rst_b(rst_b),
        .d(midscale_sel),
        .q(msel_s)
    );

    assign load_n_s = pins_s[1:0];
    assign cs_n_s = pins_s[2];
    assign sleep_n_s = pins_s[3];

    // Clear asserts the register reset at once and releases it in step with clk
    assign clear_hold_b = rst_b & register_clear_n;

    always_ff @(posedge clk or negedge clear_hold_b) begin
        if (!clear_hold_b) begin
            clr_meta_r <= 1'b0;
            clr_sync_r <= 1'b0;
        end else begin
            clr_meta_r <= dsl_pkg::PIN_IDLE_HIGH;
            clr_sync_r <= clr_meta_r;
        end
    end

    assign clr_rst_b = clr_sync_r;

    // Reset value choice. It is frozen when clear releases, so that a later move
    // of midscale select cannot flip the top bit before the registers settle.
    logic sel_r;
    logic sel_nxt;
    logic sel_now;

    always_comb begin
        sel_nxt = sel_r;
        if (!clr_rst_b) begin
            sel_nxt = msel_s;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sel_r <= dsl_pkg::CODE_RST_BIT;
        end else begin
            sel_r <= sel_nxt;
        end
    end

    // While clear is held the choice follows the pin; afterwards the held copy
    assign sel_now = clr_rst_b ? sel_r : msel_s;

    // Quiet-link tracker decides when the shift word may be copied into clk
    dsl_pkg::dsl_link_state_t state_r;
    dsl_pkg::dsl_link_state_t state_nxt;
    logic [1:0] settle_cnt_r;
    logic [1:0] settle_cnt_nxt;
    logic [DAC_W-1:0] mirror_r;
    logic [DAC_W-1:0] mirror_nxt;

    always_comb begin
        state_nxt = state_r;
        settle_cnt_nxt = settle_cnt_r;
        mirror_nxt = mirror_r;
        case (state_r)
            dsl_pkg::DSL_LINK_IDLE: begin
                if (!cs_n_s) begin
                    state_nxt = dsl_pkg::DSL_LINK_BUSY;
                end
            end
            dsl_pkg::DSL_LINK_BUSY: begin
                settle_cnt_nxt = 2'h0;
                if (cs_n_s) begin
                    state_nxt = dsl_pkg::DSL_LINK_SETTLE;
                end
            end
            dsl_pkg::DSL_LINK_SETTLE: begin
                if (!cs_n_s) begin
                    state_nxt = dsl_pkg::DSL_LINK_BUSY;
                end else if (settle_cnt_r == dsl_pkg::SETTLE_CYCLES - 2'h1) begin
                    // Word has not moved for several cycles, so all bits agree
                    mirror_nxt = shift_word;
                    state_nxt = dsl_pkg::DSL_LINK_IDLE;
                end else begin
                    settle_cnt_nxt = settle_cnt_r + 2'h1;
                end
            end
            default: begin
                state_nxt = dsl_pkg::DSL_LINK_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= dsl_pkg::DSL_LINK_IDLE;
            settle_cnt_r <= 2'h0;
            mirror_r <= {DAC_W{dsl_pkg::SHIFT_RST_BIT}};
        end else begin
            state_r <= state_nxt;
            settle_cnt_r <= settle_cnt_nxt;
            mirror_r <= mirror_nxt;
        end
    end

    // DAC holding registers. The top bit is kept twice, once clearing to zero
    // and once presetting to one, so that clear stays a constant-only reset.
    logic [DAC_W-1:0] code [NCH];

    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++) begin : g_chan
            logic [DAC_W-2:0] low_r;
            logic [DAC_W-2:0] low_nxt;
            logic msb_zero_r;
            logic msb_mid_r;
            logic msb_nxt;
            logic msb_now;

            assign msb_now = sel_now ? msb_mid_r : msb_zero_r;

            always_comb begin
                low_nxt = low_r;
                msb_nxt = msb_now;
                // Strobe is a level and ignores chip select entirely
                if (!load_n_s[ch]) begin
                    low_nxt = mirror_r[DAC_W-2:0];
                    msb_nxt = mirror_r[DAC_W-1];
                end
            end

            always_ff @(posedge clk or negedge clr_rst_b) begin
                if (!clr_rst_b) begin
                    low_r <= {(DAC_W-1){dsl_pkg::CODE_RST_BIT}};
                    msb_zero_r <= dsl_pkg::CODE_RST_BIT;
                    msb_mid_r <= dsl_pkg::MID_MSB_BIT;
                end else begin
                    low_r <= low_nxt;
                    msb_zero_r <= msb_nxt;
                    msb_mid_r <= msb_nxt;
                end
            end

            assign code[ch] = {msb_now, low_r};
        end
    endgenerate

    // Sleep only powers the converters down; registers keep running
    assign dac_code_a = code[dsl_pkg::CHAN_A];
    assign dac_code_b = code[dsl_pkg::CHAN_B];
    assign converter_sleep = !sleep_n_s;
    assign frame_active = state_r != dsl_pkg::DSL_LINK_IDLE;

    // Checks
    chk_clear_zero_code: assert property (@(posedge clk) disable iff (!rst_b)
        (!clr_rst_b && !msel_s) |-> (dac_code_a == '0 && dac_code_b == '0))
        else $error("clear with midscale select low did not give zero");

    chk_clear_mid_code: assert property (@(posedge clk) disable iff (!rst_b)
        (!clr_rst_b && msel_s) |-> (dac_code_a == {1'b1, {(DAC_W-1){1'b0}}} &&
        dac_code_b == {1'b1, {(DAC_W-1){1'b0}}}))
        else $error("clear with midscale select high did not give midscale");

    chk_clear_beats_load: assert property (@(posedge clk) disable iff (!rst_b)
        (!clr_rst_b && !load_n_s[0]) [*2] |-> dac_code_a[DAC_W-2:0] == '0)
        else $error("load strobe overrode an active clear");

    chk_load_a_follow: assert property (@(posedge clk) disable iff (!rst_b)
        (clr_rst_b && !load_n_s[0]) ##1 clr_rst_b |-> dac_code_a == $past(mirror_r))
        else $error("channel A register did not take the shift word");

    chk_load_b_follow: assert property (@(posedge clk) disable iff (!rst_b)
        (clr_rst_b && !load_n_s[1] && cs_n_s) ##1 clr_rst_b |->
        dac_code_b == $past(mirror_r))
        else $error("channel B register did not take the shift word");

    chk_level_follow_b: assert property (@(posedge clk) disable iff (!rst_b)
        (clr_rst_b && !load_n_s[1]) [*3] |-> dac_code_b == $past(mirror_r))
        else $error("held strobe did not keep channel B following");

    chk_release_keep: assert property (@(posedge clk) disable iff (!rst_b)
        ($rose(clr_rst_b) && &load_n_s) |=>
        ($stable(dac_code_a) && $stable(dac_code_b)))
        else $error("preset code moved as clear released");

    chk_copy_word: assert property (@(posedge clk) disable iff (!rst_b)
        (state_r == dsl_pkg::DSL_LINK_SETTLE && cs_n_s &&
        settle_cnt_r == dsl_pkg::SETTLE_CYCLES - 2'h1) |=> mirror_r == $past(shift_word))
        else $error("quiet shift word was not copied across");

    property p_level_follow;
        @(posedge clk) disable iff (!rst_b)
        (clr_rst_b && !load_n_s[0]) [*3] |-> dac_code_a == $past(mirror_r, 1);
    endproperty
    chk_level_follow: assert property (p_level_follow)
        else $error("held strobe did not keep channel A following");

    chk_no_load_hold: assert property (@(posedge clk) disable iff (!rst_b)
        (clr_rst_b && load_n_s[0] && msel_s == $past(msel_s)) ##1
        (clr_rst_b && load_n_s[0]) |-> $stable(dac_code_a))
        else $error("channel A changed without a strobe");

    chk_mirror_busy: assert property (@(posedge clk) disable iff (!rst_b)
        state_r == dsl_pkg::DSL_LINK_BUSY |=> $stable(mirror_r))
        else $error("copied word changed during a frame");

    chk_sleep_level: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(sleep_n_s) |-> converter_sleep ##1 (converter_sleep || sleep_n_s))
        else $error("sleep output did not follow the sleep pin");

    chk_settle_len: assert property (@(posedge clk) disable iff (!rst_b)
        (state_r == dsl_pkg::DSL_LINK_BUSY && cs_n_s) ##1 cs_n_s [*2] |=>
        state_r == dsl_pkg::DSL_LINK_IDLE)
        else $error("word copy not done two cycles after the frame");

    cov_load_both: cover property (@(posedge clk) disable iff (!rst_b)
        clr_rst_b && load_n_s == 2'h0);
    cov_load_in_sleep: cover property (@(posedge clk) disable iff (!rst_b)
        converter_sleep && !load_n_s[0] ##1 sleep_n_s);
    cov_mid_clear: cover property (@(posedge clk) disable iff (!rst_b)
        !clr_rst_b && msel_s);
    cov_frame_copy: cover property (@(posedge clk) disable iff (!rst_b)
        state_r == dsl_pkg::DSL_LINK_SETTLE ##1 state_r == dsl_pkg::DSL_LINK_IDLE);

endmodule

// ---- sim/dsl_host_model.sv ----
// Purpose: Host side of the serial link; sends frames top bit first.
// Assumes: The link clock stands low outside frames, period 48 ns.
// Notes: The data line shows the inverse of its last bit after the final clock, half a period before chip select releases.
`timescale 1ns/1ps
module dsl_host_model (
    output logic sclk,
    output logic chip_select_n,
    output logic serial_data_in
);
    localparam time HALF = 24;
    initial begin
        sclk = 1'b0;
        chip_select_n = 1'b1;
        serial_data_in = 1'b0;
    end
    // Select stays high when cs_n is 1, so the edges must be ignored
    task automatic send(input logic [15:0] word, input int nbits, input logic cs_n);
        chip_select_n = cs_n;
        #100;
        for (int i = nbits - 1; i >= 0; i--) begin
            serial_data_in = word[i];
            #HALF sclk = 1'b1;
            #HALF sclk = 1'b0;
        end
        serial_data_in = ~serial_data_in;
        #HALF chip_select_n = 1'b1;
    endtask
endmodule

// ---- sim/tb_dsl_dual_dac_load.sv ----
// Purpose: Self-checking bench for the dual DAC serial load logic.
// Assumes: Strobes, clear, midscale select and sleep driven 2 ns after clk rises.
// Notes: A second, ten-bit instance shares every input and checks the narrow code.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb_dsl_dual_dac_load;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic load_chan_a_n = 1'b1;
    logic load_chan_b_n = 1'b1;
    logic register_clear_n = 1'b1;
    logic midscale_sel = 1'b0;
    logic sleep_n = 1'b1;
    logic sclk, chip_select_n, serial_data_in;
    logic [11:0] dac_code_a, dac_code_b;
    logic [9:0] nar_code_a, nar_code_b;
    logic converter_sleep, frame_active;
    int bad_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    always #12.5 clk = ~clk;
    dsl_host_model host (
        .sclk(sclk),
        .chip_select_n(chip_select_n),
        .serial_data_in(serial_data_in)
    );
    dsl_dual_dac_load #(.DAC_W(12)) dut (
        .clk(clk),
        .rst_b(rst_b),
        .sclk(sclk),
        .chip_select_n(chip_select_n),
        .serial_data_in(serial_data_in),
        .load_chan_a_n(load_chan_a_n),
        .load_chan_b_n(load_chan_b_n),
        .register_clear_n(register_clear_n),
        .midscale_sel(midscale_sel),
        .sleep_n(sleep_n),
        .dac_code_a(dac_code_a),
        .dac_code_b(dac_code_b),
        .converter_sleep(converter_sleep),
        .frame_active(frame_active)
    );
    dsl_dual_dac_load #(.DAC_W(10)) dut_narrow (
        .clk(clk),
        .rst_b(rst_b),
        .sclk(sclk),
        .chip_select_n(chip_select_n),
        .serial_data_in(serial_data_in),
        .load_chan_a_n(load_chan_a_n),
        .load_chan_b_n(load_chan_b_n),
        .register_clear_n(register_clear_n),
        .midscale_sel(midscale_sel),
        .sleep_n(sleep_n),
        .dac_code_a(nar_code_a),
        .dac_code_b(nar_code_b),
        .converter_sleep(),
        .frame_active()
    );
    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Cycle ceiling well above the few hundred cycles the tests need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            bad_count++;
            summarize();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic strobe(input logic a_n, input logic b_n);
        @(posedge clk);
        #2;
        load_chan_a_n = a_n;
        load_chan_b_n = b_n;
        tick(4);
    endtask
    // Bounded wait for the word to cross into the clk side
    task automatic frame(input logic [15:0] w, input int n, input logic cs_n);
        host.send(w, n, cs_n);
        for (int k = 0; k < 20 && frame_active !== 1'b0; k++) begin
            @(posedge clk);
            #2;
        end
        tick(2);
        `CHK("frame_active", 1'b0, frame_active)
    endtask
    task automatic codes(input logic [11:0] ea, input logic [11:0] eb);
        `CHK("dac_code_a", ea, dac_code_a)
        `CHK("dac_code_b", eb, dac_code_b)
    endtask
    task automatic codes_n(input logic [9:0] ea, input logic [9:0] eb);
        `CHK("nar_code_a", ea, nar_code_a)
        `CHK("nar_code_b", eb, nar_code_b)
    endtask
    initial begin
        tick(20);
        rst_b = 1'b1;
        tick(3);
        codes(12'h000, 12'h000);
        `CHK("converter_sleep", 1'b0, converter_sleep)
        $display("test reset done");
        frame(16'h0a5c, 12, 1'b0);
        strobe(1'b0, 1'b1);
        codes(12'ha5c, 12'h000);
        codes_n(10'h25c, 10'h000);
        strobe(1'b1, 1'b1);
        $display("test load_a done");
        frame(16'hf3c7, 16, 1'b0);
        strobe(1'b0, 1'b0);
        codes(12'h3c7, 12'h3c7);
        codes_n(10'h3c7, 10'h3c7);
        strobe(1'b1, 1'b1);
        $display("test surplus_both done");
        frame(16'h00ff, 12, 1'b1);
        strobe(1'b1, 1'b0);
        codes(12'h3c7, 12'h3c7);
        strobe(1'b1, 1'b1);
        $display("test deselected done");
        strobe(1'b0, 1'b1);
        frame(16'h0123, 12, 1'b0);
        tick(4);
        codes(12'h123, 12'h3c7);
        strobe(1'b1, 1'b1);
        $display("test level done");
        midscale_sel = 1'b1;
        tick(3);
        register_clear_n = 1'b0;
        #1;
        codes(12'h800, 12'h800);
        codes_n(10'h200, 10'h200);
        strobe(1'b0, 1'b0);
        codes(12'h800, 12'h800);
        strobe(1'b1, 1'b1);
        register_clear_n = 1'b1;
        midscale_sel = 1'b0;
        tick(4);
        codes(12'h800, 12'h800);
        register_clear_n = 1'b0;
        #1;
        codes(12'h000, 12'h000);
        tick(1);
        register_clear_n = 1'b1;
        tick(3);
        $display("test clear done");
        sleep_n = 1'b0;
        tick(3);
        `CHK("converter_sleep", 1'b1, converter_sleep)
        frame(16'h0456, 12, 1'b0);
        strobe(1'b0, 1'b1);
        strobe(1'b1, 1'b1);
        codes(12'h456, 12'h000);
        sleep_n = 1'b1;
        tick(3);
        `CHK("converter_sleep", 1'b0, converter_sleep)
        codes(12'h456, 12'h000);
        $display("test sleep done");
        summarize();
    end
endmodule
